// ### err_irq_pkg.sv
// constants and types shared by the error status block and its input filter
`default_nettype none
package err_irq_pkg;

	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0] ERR_FLAGS_IDX = 8'h32;
	localparam logic [7:0] ERR_STAT_EN_IDX = 8'h33;
	localparam logic [7:0] ERR_SIG_EN_IDX = 8'h34;
	localparam logic [7:0] DMA_ERR_STAT_IDX = 8'h35;
	localparam logic [7:0] AUTO_STOP_STAT_IDX = 8'h36;
	localparam logic [7:0] PWR_CTRL_IDX = 8'h37;
	localparam int ADDR_W = 12;
	localparam logic [11:0] ERR_FLAGS_ADDR = {2'h0, ERR_FLAGS_IDX, 2'h0};
	localparam logic [11:0] ERR_STAT_EN_ADDR = {2'h0, ERR_STAT_EN_IDX, 2'h0};
	localparam logic [11:0] ERR_SIG_EN_ADDR = {2'h0, ERR_SIG_EN_IDX, 2'h0};
	localparam logic [11:0] DMA_ERR_STAT_ADDR = {2'h0, DMA_ERR_STAT_IDX, 2'h0};
	localparam logic [11:0] AUTO_STOP_STAT_ADDR = {2'h0, AUTO_STOP_STAT_IDX, 2'h0};
	localparam logic [11:0] PWR_CTRL_ADDR = {2'h0, PWR_CTRL_IDX, 2'h0};

	// bit positions in the error flag, power control and dma error status registers
	localparam int BIT_CMD_TIMEOUT = 0;
	localparam int BIT_CMD_CRC = 1;
	localparam int BIT_CMD_END = 2;
	localparam int BIT_CMD_INDEX = 3;
	localparam int BIT_DATA_TIMEOUT = 4;
	localparam int BIT_DATA_CRC = 5;
	localparam int BIT_DATA_END = 6;
	localparam int BIT_CUR_LIMIT = 7;
	localparam int BIT_AUTO_STOP = 8;
	localparam int BIT_DESC_DMA = 9;
	localparam int VENDOR_LSB = 12;
	localparam int VENDOR_W = 4;
	localparam logic [15:0] FLAGS_IMPL_MASK = 16'hF3FF;
	localparam int PWR_ON_BIT = 0;
	localparam int DMA_VALID_BIT = 8;

	// widths and codes of side signals
	localparam int AUTO_STOP_W = 5;
	localparam int DMA_STATE_W = 2;
	localparam logic [1:0] DMA_ST_FETCH = 2'h1;
	localparam logic [2:0] WR_CRC_GOOD = 3'h2;

	// over-current sampling time
	localparam int CLK_PERIOD_NS = 10;
	localparam int OC_SAMPLE_NS = 1000;
	localparam int OC_CNT_W = 7;
	localparam logic [6:0] OC_SAMPLE_CYC =
		7'((OC_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// bus handshake states
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_RESP = 2'b10
	} apb_state_t;

	// whole state of the status block
	typedef struct packed
	{
		apb_state_t apb_state;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [15:0] flags;
		logic [15:0] stat_en;
		logic [15:0] sig_en;
		logic [4:0] auto_stat;
		logic [1:0] dma_err_state;
		logic dma_err_valid;
		logic pwr_on;
		logic irq;
	} ctrl_state_t;

	localparam ctrl_state_t CTRL_RESET = '{
		apb_state: ST_IDLE,
		pready: 1'b0,
		pslverr: 1'b0,
		prdata: 32'h00000000,
		flags: 16'h0000,
		stat_en: 16'h0000,
		sig_en: 16'h0000,
		auto_stat: 5'h00,
		dma_err_state: 2'h0,
		dma_err_valid: 1'b0,
		pwr_on: 1'b0,
		irq: 1'b0
	};

	// whole state of the over-current filter
	typedef struct packed
	{
		logic sync1;
		logic sync2;
		logic [6:0] cnt;
		logic det;
	} oc_state_t;

endpackage
`default_nettype wire

// ### oc_sense_filter.sv
// over-current pin synchroniser with a sampling-time filter
`timescale 1ns/1ps
`default_nettype none
module oc_sense_filter
(
	input wire logic clk, // system clock
	input wire logic srst, // synchronous reset, active high
	input wire logic oc_pin, // raw over-current pin, asynchronous
	output logic oc_det // filtered over-current, registered
);
	err_irq_pkg::oc_state_t s_reg;
	err_irq_pkg::oc_state_t s_next;

	// a short glitch on the sense pin must not cut card power, so the level
	// has to stand for the whole sampling time before it counts
	always_comb
	begin
		s_next = s_reg;
		s_next.sync1 = oc_pin;
		s_next.sync2 = s_reg.sync1;
		if (!s_reg.sync2)
		begin
			s_next.cnt = '0;
			s_next.det = 1'b0;
		end
		else if (s_reg.cnt >= err_irq_pkg::OC_SAMPLE_CYC - 7'h01)
		begin
			s_next.det = 1'b1; // RL15
		end
		else
		begin
			s_next.cnt = s_reg.cnt + 7'h01;
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (srst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign oc_det = s_reg.det;

	property p_oc_sampling;
		@(posedge clk) disable iff (srst)
		$rose(s_reg.det) |-> $past(s_reg.cnt) == err_irq_pkg::OC_SAMPLE_CYC - 7'h01;
	endproperty
	a_oc_sampling: assert property (p_oc_sampling) else $error("over-current flagged early"); // RL15

endmodule // oc_sense_filter
`default_nettype wire

// ### err_irq_status.sv
// error interrupt status register with enables, capture and interrupt output
//
// Operation
// RL1: flags record only when status-enable bit set
// RL2: interrupt when enabled flag reads one
// RL3: writing one clears; zero leaves flag
// RL4: one write clears any flag combination
// RL5: vendor flags 15..12 also write-one-to-clear
// RL6: descriptor DMA error sets bit 9
// RL7: capture engine state on DMA error
// RL8: invalid descriptor during fetch raises DMA error
// RL9: invalid descriptor reports fetch state
// RL10: bit 8 on auto stop status rise
// RL11: bit 8 when auto stop skipped
// RL12: power bit requests card bus power
// RL13: over-current cuts power, sets bit 7
// RL14: bit 7 one means power removed
// RL15: sampling delay; no limiter keeps bit 7 zero
// RL16: bit 6 on zero end bit
// RL17: fixed flag bit positions 5..0
// RL18: data CRC on mismatch or bad token
// RL19: bits 11..10 read zero, ignore writes
// RL20: set wins over simultaneous clear
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module err_irq_status
#(
	parameter bit HAS_CURRENT_LIMIT = 1'b1 // current limiting fitted
)
(
	input wire logic REF_CLK, // system clock, 100 MHz
	input wire logic SRST, // synchronous reset, active high
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb enable
	input wire logic PWRITE, // apb direction, high for write
	input wire logic [11:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	input wire logic [3:0] PSTRB, // apb byte strobes
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error on unmapped address
	input wire logic CMD_TIMEOUT_ERR, // pulse: response timeout
	input wire logic CMD_CRC_ERR, // pulse: response crc error
	input wire logic CMD_END_BIT_ERR, // pulse: response end bit zero
	input wire logic CMD_INDEX_ERR, // pulse: response index mismatch
	input wire logic DATA_TIMEOUT_ERR, // pulse: data timeout
	input wire logic RD_CRC_MISMATCH, // pulse: read data crc mismatch
	input wire logic WR_CRC_STB, // pulse: write crc status token taken
	input wire logic [2:0] WR_CRC_TOKEN, // write crc status token
	input wire logic RD_END_STB, // pulse: read end bit sampled
	input wire logic RD_END_BIT, // sampled read end bit
	input wire logic CRC_END_STB, // pulse: crc status end bit sampled
	input wire logic CRC_END_BIT, // sampled crc status end bit
	input wire logic [4:0] AUTO_STOP_ERR, // pulses: automatic stop errors
	input wire logic AUTO_STOP_SKIPPED, // pulse: automatic stop not issued
	input wire logic DMA_ERR, // pulse: descriptor dma engine error
	input wire logic [1:0] DMA_STATE, // descriptor dma engine state
	input wire logic DMA_DESC_STB, // pulse: descriptor fetched
	input wire logic DMA_DESC_VALID, // valid flag of fetched descriptor
	input wire logic [3:0] VENDOR_ERR, // pulses: vendor error events
	input wire logic OVERCURRENT_IN, // over-current sense pin, async
	output logic CARD_POWER_EN, // card bus power supply on
	output logic ERR_IRQ // error interrupt, active high level
);
	err_irq_pkg::ctrl_state_t s_reg;
	err_irq_pkg::ctrl_state_t s_next;
	logic oc_det;
	logic acc_start;
	logic wr_done;
	logic [15:0] wdata16;
	logic [15:0] ev;
	logic [4:0] auto_rise;
	logic desc_invalid;
	logic dma_fault;
	logic oc_trip;
	logic data_crc_ev;
	logic data_end_ev;
	logic [15:0] impl_mask;

	// synchronised and sampled over-current sense
	oc_sense_filter u_oc_filter
	(
		.clk(REF_CLK),
		.srst(SRST),
		.oc_pin(OVERCURRENT_IN),
		.oc_det(oc_det)
	);

	// bus qualifiers; writes land only at the edge that completes the access
	assign acc_start = PSEL & PENABLE & (s_reg.apb_state == err_irq_pkg::ST_IDLE);
	assign wr_done = PSEL & PENABLE & PWRITE & s_reg.pready;
	assign wdata16 = PWDATA[15:0] & {{8{PSTRB[1]}}, {8{PSTRB[0]}}};

	// event detection for each flag
	assign auto_rise = AUTO_STOP_ERR & ~s_reg.auto_stat; // RL10
	assign desc_invalid = DMA_DESC_STB & ~DMA_DESC_VALID & (DMA_STATE == err_irq_pkg::DMA_ST_FETCH); // RL8
	assign dma_fault = DMA_ERR | desc_invalid; // RL6
	assign oc_trip = HAS_CURRENT_LIMIT & oc_det & s_reg.pwr_on; // RL13
	assign data_crc_ev = RD_CRC_MISMATCH | (WR_CRC_STB & (WR_CRC_TOKEN != err_irq_pkg::WR_CRC_GOOD)); // RL18
	assign data_end_ev = (RD_END_STB & ~RD_END_BIT) | (CRC_END_STB & ~CRC_END_BIT); // RL16
	// without a limiter bit 7 can never be set; reserved bits are never stored
	assign impl_mask = HAS_CURRENT_LIMIT ? err_irq_pkg::FLAGS_IMPL_MASK
		: (err_irq_pkg::FLAGS_IMPL_MASK & 16'hFF7F); // RL15 RL19

	// raw events placed at their fixed flag positions
	always_comb
	begin
		ev = 16'h0000;
		ev[err_irq_pkg::BIT_CMD_TIMEOUT] = CMD_TIMEOUT_ERR; // RL17
		ev[err_irq_pkg::BIT_CMD_CRC] = CMD_CRC_ERR; // RL17
		ev[err_irq_pkg::BIT_CMD_END] = CMD_END_BIT_ERR; // RL17
		ev[err_irq_pkg::BIT_CMD_INDEX] = CMD_INDEX_ERR; // RL17
		ev[err_irq_pkg::BIT_DATA_TIMEOUT] = DATA_TIMEOUT_ERR; // RL17
		ev[err_irq_pkg::BIT_DATA_CRC] = data_crc_ev; // RL17
		ev[err_irq_pkg::BIT_DATA_END] = data_end_ev; // RL16
		ev[err_irq_pkg::BIT_CUR_LIMIT] = oc_trip; // RL13
		ev[err_irq_pkg::BIT_AUTO_STOP] = (|auto_rise) | AUTO_STOP_SKIPPED; // RL10 RL11
		ev[err_irq_pkg::BIT_DESC_DMA] = dma_fault; // RL6
		ev[err_irq_pkg::VENDOR_LSB +: err_irq_pkg::VENDOR_W] = VENDOR_ERR; // RL5
	end

	// next-state logic: bus handshake, register writes, flag update
	always_comb
	begin
		s_next = s_reg;
		s_next.pready = 1'b0;
		s_next.pslverr = 1'b0;
		case (s_reg.apb_state)
			err_irq_pkg::ST_IDLE:
			begin
				// one wait state so that read data comes from a flip-flop
				if (acc_start)
				begin
					s_next.apb_state = err_irq_pkg::ST_RESP;
					s_next.pready = 1'b1;
					s_next.prdata = 32'h00000000;
					if (PADDR == err_irq_pkg::ERR_FLAGS_ADDR)
						s_next.prdata[15:0] = s_reg.flags; // RL19
					else if (PADDR == err_irq_pkg::ERR_STAT_EN_ADDR)
						s_next.prdata[15:0] = s_reg.stat_en;
					else if (PADDR == err_irq_pkg::ERR_SIG_EN_ADDR)
						s_next.prdata[15:0] = s_reg.sig_en;
					else if (PADDR == err_irq_pkg::DMA_ERR_STAT_ADDR)
						s_next.prdata[8:0] = {s_reg.dma_err_valid, 6'h00, s_reg.dma_err_state};
					else if (PADDR == err_irq_pkg::AUTO_STOP_STAT_ADDR)
						s_next.prdata[4:0] = s_reg.auto_stat;
					else if (PADDR == err_irq_pkg::PWR_CTRL_ADDR)
						s_next.prdata[err_irq_pkg::PWR_ON_BIT] = s_reg.pwr_on;
					else
						s_next.pslverr = 1'b1;
				end
			end
			err_irq_pkg::ST_RESP:
			begin
				s_next.apb_state = err_irq_pkg::ST_IDLE;
				s_next.prdata = 32'h00000000;
			end
			default:
			begin
				s_next.apb_state = err_irq_pkg::ST_IDLE;
			end
		endcase

		// enable registers; reserved positions never hold a one
		if (wr_done && PADDR == err_irq_pkg::ERR_STAT_EN_ADDR)
			s_next.stat_en = (s_reg.stat_en & ~{{8{PSTRB[1]}}, {8{PSTRB[0]}}}) | (wdata16 & impl_mask);
		if (wr_done && PADDR == err_irq_pkg::ERR_SIG_EN_ADDR)
			s_next.sig_en = (s_reg.sig_en & ~{{8{PSTRB[1]}}, {8{PSTRB[0]}}}) | (wdata16 & impl_mask);

		// card power: software asks, an over-current trip takes it away
		if (wr_done && PADDR == err_irq_pkg::PWR_CTRL_ADDR && PSTRB[0])
			s_next.pwr_on = PWDATA[err_irq_pkg::PWR_ON_BIT]; // RL12
		if (oc_trip)
			s_next.pwr_on = 1'b0; // RL13 RL14

		// automatic stop status: hardware sets, software clears by writing one
		if (wr_done && PADDR == err_irq_pkg::AUTO_STOP_STAT_ADDR)
			s_next.auto_stat = s_reg.auto_stat & ~wdata16[4:0];
		s_next.auto_stat = s_next.auto_stat | AUTO_STOP_ERR; // RL20

		// engine state captured at the moment of the fault
		if (desc_invalid)
		begin
			s_next.dma_err_state = err_irq_pkg::DMA_ST_FETCH; // RL9
			s_next.dma_err_valid = 1'b1;
		end
		else if (DMA_ERR)
		begin
			s_next.dma_err_state = DMA_STATE; // RL7
			s_next.dma_err_valid = 1'b1;
		end

		// write-one-to-clear, applied to all bits at once; a new event wins
		if (wr_done && PADDR == err_irq_pkg::ERR_FLAGS_ADDR)
			s_next.flags = s_reg.flags & ~wdata16; // RL3 RL4 RL5
		s_next.flags = (s_next.flags | (ev & s_reg.stat_en)) & impl_mask; // RL1 RL20

		// interrupt follows the stored flags without an extra cycle of lag
		s_next.irq = |(s_next.flags & s_next.sig_en); // RL2
	end

	// state register
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			s_reg <= err_irq_pkg::CTRL_RESET;
		else
			s_reg <= s_next;
	end

	// outputs straight from the state register
	assign PRDATA = s_reg.prdata;
	assign PREADY = s_reg.pready;
	assign PSLVERR = s_reg.pslverr;
	assign CARD_POWER_EN = s_reg.pwr_on;
	assign ERR_IRQ = s_reg.irq;

	property p_gate;
		@(posedge REF_CLK) disable iff (SRST)
		((s_reg.flags & ~$past(s_reg.flags) & ~$past(s_reg.stat_en)) == 16'h0000);
	endproperty
	a_gate: assert property (p_gate) else $error("flag set while disabled"); // RL1

	property p_irq;
		@(posedge REF_CLK) disable iff (SRST)
		ERR_IRQ == (|(s_reg.flags & s_reg.sig_en));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt disagrees with flags"); // RL2

	property p_clear_only_by_write;
		@(posedge REF_CLK) disable iff (SRST)
		((s_reg.flags & ~s_next.flags) != 16'h0000)
			|-> (wr_done && PADDR == err_irq_pkg::ERR_FLAGS_ADDR);
	endproperty
	a_clear_only_by_write: assert property (p_clear_only_by_write) else $error("flag lost"); // RL3

	// every enabled event that meets a clearing write must still stand afterwards
	property p_set_wins;
		@(posedge REF_CLK) disable iff (SRST)
		(wr_done && PADDR == err_irq_pkg::ERR_FLAGS_ADDR)
			|=> ((s_reg.flags & $past(ev) & $past(s_reg.stat_en) & impl_mask)
			== ($past(ev) & $past(s_reg.stat_en) & impl_mask));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost on clear"); // RL20

	property p_reserved;
		@(posedge REF_CLK) disable iff (SRST)
		s_reg.flags[11:10] == 2'h0 && s_reg.stat_en[11:10] == 2'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set"); // RL19

	property p_power_cut;
		@(posedge REF_CLK) disable iff (SRST)
		(oc_trip && s_reg.stat_en[err_irq_pkg::BIT_CUR_LIMIT])
			|=> !CARD_POWER_EN && s_reg.flags[err_irq_pkg::BIT_CUR_LIMIT];
	endproperty
	a_power_cut: assert property (p_power_cut) else $error("power not cut"); // RL13

	property p_no_limiter;
		@(posedge REF_CLK) disable iff (SRST)
		!HAS_CURRENT_LIMIT |-> !s_reg.flags[err_irq_pkg::BIT_CUR_LIMIT];
	endproperty
	a_no_limiter: assert property (p_no_limiter) else $error("bit 7 set without limiter"); // RL15

	property p_auto_stop;
		@(posedge REF_CLK) disable iff (SRST)
		((|auto_rise) && s_reg.stat_en[err_irq_pkg::BIT_AUTO_STOP])
			|=> s_reg.flags[err_irq_pkg::BIT_AUTO_STOP];
	endproperty
	a_auto_stop: assert property (p_auto_stop) else $error("auto stop flag missed"); // RL10

	property p_fetch_state;
		@(posedge REF_CLK) disable iff (SRST)
		(desc_invalid && s_reg.stat_en[err_irq_pkg::BIT_DESC_DMA])
			|=> s_reg.flags[err_irq_pkg::BIT_DESC_DMA]
			&& s_reg.dma_err_state == err_irq_pkg::DMA_ST_FETCH;
	endproperty
	a_fetch_state: assert property (p_fetch_state) else $error("invalid descriptor missed"); // RL9

	property p_ready_timing;
		@(posedge REF_CLK) disable iff (SRST)
		acc_start |=> PREADY ##1 !PREADY;
	endproperty
	a_ready_timing: assert property (p_ready_timing) else $error("bad ready timing");

endmodule // err_irq_status
`default_nettype wire

// ### test_error_interrupt_status.sv
// self-checking bench for the error status register block
`timescale 1ns/1ps
`default_nettype none
module test_error_interrupt_status;
	typedef struct packed
	{
		logic [3:0] k;
		logic [4:0] v;
		logic [15:0] f;
		logic [15:0] d;
	} row_t;
	// event source, side value, expected flags, expected dma capture
	localparam row_t ROWS [18] = '{
		'{4'h0, 5'h00, 16'h0001, 16'h0000}, '{4'h1, 5'h00, 16'h0002, 16'h0000},
		'{4'h2, 5'h00, 16'h0004, 16'h0000}, '{4'h3, 5'h00, 16'h0008, 16'h0000},
		'{4'h4, 5'h00, 16'h0010, 16'h0000}, '{4'h5, 5'h00, 16'h0020, 16'h0000},
		'{4'h6, 5'h05, 16'h0020, 16'h0000}, '{4'h6, 5'h02, 16'h0000, 16'h0000},
		'{4'h7, 5'h00, 16'h0040, 16'h0000}, '{4'h7, 5'h01, 16'h0000, 16'h0000},
		'{4'h8, 5'h00, 16'h0040, 16'h0000}, '{4'h9, 5'h04, 16'h0100, 16'h0000},
		'{4'hA, 5'h00, 16'h0100, 16'h0000}, '{4'hB, 5'h03, 16'h0200, 16'h0103},
		'{4'hC, 5'h01, 16'h0200, 16'h0101}, '{4'hC, 5'h05, 16'h0000, 16'h0101},
		'{4'hC, 5'h02, 16'h0000, 16'h0101}, '{4'hD, 5'h0F, 16'hF000, 16'h0101}};
	logic REF_CLK = 1'b0;
	logic SRST = 1'b1;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h00000000;
	logic [3:0] PSTRB = 4'hF;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic CMD_TIMEOUT_ERR = 1'b0, CMD_CRC_ERR = 1'b0, CMD_END_BIT_ERR = 1'b0;
	logic CMD_INDEX_ERR = 1'b0, DATA_TIMEOUT_ERR = 1'b0, RD_CRC_MISMATCH = 1'b0;
	logic WR_CRC_STB = 1'b0, RD_END_STB = 1'b0, RD_END_BIT = 1'b1;
	logic CRC_END_STB = 1'b0, CRC_END_BIT = 1'b1, AUTO_STOP_SKIPPED = 1'b0;
	logic DMA_ERR = 1'b0, DMA_DESC_STB = 1'b0, DMA_DESC_VALID = 1'b1;
	logic OVERCURRENT_IN = 1'b0;
	logic [2:0] WR_CRC_TOKEN = 3'h2;
	logic [4:0] AUTO_STOP_ERR = 5'h00;
	logic [1:0] DMA_STATE = 2'h0;
	logic [3:0] VENDOR_ERR = 4'h0;
	logic CARD_POWER_EN;
	logic ERR_IRQ;
	logic [31:0] q;
	logic e;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;

	err_irq_status dut_u
	(
		.REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .CMD_TIMEOUT_ERR(CMD_TIMEOUT_ERR), .CMD_CRC_ERR(CMD_CRC_ERR),
		.CMD_END_BIT_ERR(CMD_END_BIT_ERR), .CMD_INDEX_ERR(CMD_INDEX_ERR),
		.DATA_TIMEOUT_ERR(DATA_TIMEOUT_ERR), .RD_CRC_MISMATCH(RD_CRC_MISMATCH),
		.WR_CRC_STB(WR_CRC_STB), .WR_CRC_TOKEN(WR_CRC_TOKEN), .RD_END_STB(RD_END_STB),
		.RD_END_BIT(RD_END_BIT), .CRC_END_STB(CRC_END_STB), .CRC_END_BIT(CRC_END_BIT),
		.AUTO_STOP_ERR(AUTO_STOP_ERR), .AUTO_STOP_SKIPPED(AUTO_STOP_SKIPPED),
		.DMA_ERR(DMA_ERR), .DMA_STATE(DMA_STATE), .DMA_DESC_STB(DMA_DESC_STB),
		.DMA_DESC_VALID(DMA_DESC_VALID), .VENDOR_ERR(VENDOR_ERR),
		.OVERCURRENT_IN(OVERCURRENT_IN), .CARD_POWER_EN(CARD_POWER_EN), .ERR_IRQ(ERR_IRQ)
	);

	// copy without a limiter under the same stimulus; its assertions keep bit 7 at zero
	err_irq_status #(.HAS_CURRENT_LIMIT(1'b0)) nolim_u
	(
		.REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(), .PREADY(),
		.PSLVERR(), .CMD_TIMEOUT_ERR(CMD_TIMEOUT_ERR), .CMD_CRC_ERR(CMD_CRC_ERR),
		.CMD_END_BIT_ERR(CMD_END_BIT_ERR), .CMD_INDEX_ERR(CMD_INDEX_ERR),
		.DATA_TIMEOUT_ERR(DATA_TIMEOUT_ERR), .RD_CRC_MISMATCH(RD_CRC_MISMATCH),
		.WR_CRC_STB(WR_CRC_STB), .WR_CRC_TOKEN(WR_CRC_TOKEN), .RD_END_STB(RD_END_STB),
		.RD_END_BIT(RD_END_BIT), .CRC_END_STB(CRC_END_STB), .CRC_END_BIT(CRC_END_BIT),
		.AUTO_STOP_ERR(AUTO_STOP_ERR), .AUTO_STOP_SKIPPED(AUTO_STOP_SKIPPED),
		.DMA_ERR(DMA_ERR), .DMA_STATE(DMA_STATE), .DMA_DESC_STB(DMA_DESC_STB),
		.DMA_DESC_VALID(DMA_DESC_VALID), .VENDOR_ERR(VENDOR_ERR),
		.OVERCURRENT_IN(OVERCURRENT_IN), .CARD_POWER_EN(), .ERR_IRQ()
	);

	// 100 MHz clock
	always #5 REF_CLK = ~REF_CLK;

	// hang guard, well above the under one thousand cycles the run needs
	always @(posedge REF_CLK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("compares=%0d errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; a fresh edge first so a strobe is never set twice at once
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rq, output logic re);
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		do @(posedge REF_CLK); while (PREADY !== 1'b1);
		rq = PRDATA;
		re = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d, q, e);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000, q, e);
		chk(q, exp);
	endtask

	// one-cycle pulse on event source k; side values ride along with it
	task automatic fire(input logic [3:0] k, input logic [4:0] v);
		@(posedge REF_CLK);
		WR_CRC_TOKEN <= v[2:0];
		RD_END_BIT <= v[0];
		CRC_END_BIT <= v[0];
		DMA_STATE <= v[1:0];
		DMA_DESC_VALID <= v[2];
		case (k)
			4'h0: CMD_TIMEOUT_ERR <= 1'b1;
			4'h1: CMD_CRC_ERR <= 1'b1;
			4'h2: CMD_END_BIT_ERR <= 1'b1;
			4'h3: CMD_INDEX_ERR <= 1'b1;
			4'h4: DATA_TIMEOUT_ERR <= 1'b1;
			4'h5: RD_CRC_MISMATCH <= 1'b1;
			4'h6: WR_CRC_STB <= 1'b1;
			4'h7: RD_END_STB <= 1'b1;
			4'h8: CRC_END_STB <= 1'b1;
			4'h9: AUTO_STOP_ERR <= v;
			4'hA: AUTO_STOP_SKIPPED <= 1'b1;
			4'hB: DMA_ERR <= 1'b1;
			4'hC: DMA_DESC_STB <= 1'b1;
			default: VENDOR_ERR <= v[3:0];
		endcase
		@(posedge REF_CLK);
		{CMD_TIMEOUT_ERR, CMD_CRC_ERR, CMD_END_BIT_ERR, CMD_INDEX_ERR} <= 4'h0;
		{DATA_TIMEOUT_ERR, RD_CRC_MISMATCH, WR_CRC_STB, RD_END_STB, CRC_END_STB} <= 5'h00;
		{AUTO_STOP_SKIPPED, DMA_ERR, DMA_DESC_STB} <= 3'h0;
		AUTO_STOP_ERR <= 5'h00;
		VENDOR_ERR <= 4'h0;
	endtask

	initial
	begin
		repeat (20) @(posedge REF_CLK);
		SRST <= 1'b0;
		rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000000);
		chk({31'h0, ERR_IRQ}, 32'h00000000);
		wr(err_irq_pkg::ERR_STAT_EN_ADDR, 32'h0000FFFF);
		wr(err_irq_pkg::ERR_SIG_EN_ADDR, 32'h0000FFFF);
		rdc(err_irq_pkg::ERR_STAT_EN_ADDR, 32'h0000F3FF);
		wr(err_irq_pkg::ERR_FLAGS_ADDR, 32'h0000FFFF);
		rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000000);
		// every event source in turn: set, signal, capture, clear
		foreach (ROWS[i])
		begin
			fire(ROWS[i].k, ROWS[i].v);
			rdc(err_irq_pkg::ERR_FLAGS_ADDR, {16'h0000, ROWS[i].f});
			chk({31'h0, ERR_IRQ}, {31'h0, ROWS[i].f != 16'h0000});
			rdc(err_irq_pkg::DMA_ERR_STAT_ADDR, {16'h0000, ROWS[i].d});
			wr(err_irq_pkg::ERR_FLAGS_ADDR, {16'h0000, ROWS[i].f});
			rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000000);
		end
		// status enable off drops the event
		wr(err_irq_pkg::ERR_STAT_EN_ADDR, 32'h00000000);
		fire(4'h1, 5'h00);
		rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000000);
		wr(err_irq_pkg::ERR_STAT_EN_ADDR, 32'h0000FFFF);
		// signal enable gates only the interrupt; partial clear in one write
		wr(err_irq_pkg::ERR_SIG_EN_ADDR, 32'h00000000);
		fire(4'h0, 5'h00);
		fire(4'h2, 5'h00);
		fire(4'h4, 5'h00);
		@(posedge REF_CLK);
		chk({31'h0, ERR_IRQ}, 32'h00000000);
		wr(err_irq_pkg::ERR_SIG_EN_ADDR, 32'h00000010);
		@(posedge REF_CLK);
		chk({31'h0, ERR_IRQ}, 32'h00000001);
		wr(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000011);
		rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000004);
		@(posedge REF_CLK);
		chk({31'h0, ERR_IRQ}, 32'h00000000);
		wr(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000004);
		wr(err_irq_pkg::ERR_SIG_EN_ADDR, 32'h0000FFFF);
		// new event lands on the very edge that clears its flag
		fire(4'h3, 5'h00);
		fork
			wr(err_irq_pkg::ERR_FLAGS_ADDR, 32'h0000000A);
			begin
				repeat (3) @(posedge REF_CLK);
				CMD_CRC_ERR <= 1'b1;
				@(posedge REF_CLK);
				CMD_CRC_ERR <= 1'b0;
			end
		join
		rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000002);
		wr(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000002);
		// auto stop: a bit already at one gives no new rise
		fire(4'h9, 5'h01);
		rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000100);
		wr(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000100);
		fire(4'h9, 5'h01);
		rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000000);
		rdc(err_irq_pkg::AUTO_STOP_STAT_ADDR, 32'h00000005);
		wr(err_irq_pkg::AUTO_STOP_STAT_ADDR, 32'h0000001F);
		rdc(err_irq_pkg::AUTO_STOP_STAT_ADDR, 32'h00000000);
		fire(4'h9, 5'h01);
		rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000100);
		wr(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000100);
		// unmapped place answers with error, read-only capture ignores writes
		bus(1'b0, 12'h000, 32'h00000000, q, e);
		chk({31'h0, e}, 32'h00000001);
		chk(q, 32'h00000000);
		wr(err_irq_pkg::DMA_ERR_STAT_ADDR, 32'h00000000);
		rdc(err_irq_pkg::DMA_ERR_STAT_ADDR, 32'h00000101);
		// power on, a short glitch is filtered, a long over-current trips
		wr(err_irq_pkg::PWR_CTRL_ADDR, 32'h00000001);
		@(posedge REF_CLK);
		chk({31'h0, CARD_POWER_EN}, 32'h00000001);
		OVERCURRENT_IN <= 1'b1;
		repeat (50) @(posedge REF_CLK);
		OVERCURRENT_IN <= 1'b0;
		repeat (10) @(posedge REF_CLK);
		chk({31'h0, CARD_POWER_EN}, 32'h00000001);
		rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000000);
		OVERCURRENT_IN <= 1'b1;
		repeat (130) @(posedge REF_CLK);
		chk({31'h0, CARD_POWER_EN}, 32'h00000000);
		rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000080);
		rdc(err_irq_pkg::PWR_CTRL_ADDR, 32'h00000000);
		OVERCURRENT_IN <= 1'b0;
		wr(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000080);
		rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000000);
		// reset in mid-run wipes a pending flag
		fire(4'h0, 5'h00);
		SRST <= 1'b1;
		repeat (2) @(posedge REF_CLK);
		SRST <= 1'b0;
		rdc(err_irq_pkg::ERR_FLAGS_ADDR, 32'h00000000);
		chk({31'h0, ERR_IRQ}, 32'h00000000);
		// byte strobes: only the low lane of the enable register is written
		rdc(err_irq_pkg::ERR_STAT_EN_ADDR, 32'h00000000);
		PSTRB <= 4'h1;
		wr(err_irq_pkg::ERR_STAT_EN_ADDR, 32'h0000FFFF);
		PSTRB <= 4'hF;
		rdc(err_irq_pkg::ERR_STAT_EN_ADDR, 32'h000000FF);
		wrap_up();
	end
endmodule // test_error_interrupt_status
`default_nettype wire
